// File: cpw_pkg.sv
package cpw_pkg;
    // Avalon byte addresses, one 32-bit word per register
    localparam logic [4:0] CPW_ADDR_CONTROL = 5'h00;
    localparam logic [4:0] CPW_ADDR_HOLD_LOW = 5'h04;
    localparam logic [4:0] CPW_ADDR_HOLD_HIGH = 5'h08;
    localparam logic [4:0] CPW_ADDR_TIMER_SEL = 5'h0C;
    localparam logic [4:0] CPW_ADDR_STATUS = 5'h10;
    localparam int CPW_ADDR_W = 5;
    localparam int CPW_DATA_W = 32;

    // Control register layout
    localparam int CPW_CTL_EN_BIT = 7;
    localparam int CPW_CTL_OUT_BIT = 5;
    localparam int CPW_CTL_FMT_BIT = 4;
    localparam int CPW_CTL_MODE_LSB = 0;
    localparam int CPW_MODE_W = 4;
    localparam logic [7:0] CPW_CTL_WRITE_MASK = 8'h9F;
    localparam logic [7:0] CPW_CTL_RESET = 8'h00;
    localparam logic [7:0] CPW_HOLD_RESET = 8'h00;
    localparam logic [1:0] CPW_TSEL_RESET = 2'h0;
    localparam int CPW_STAT_EVENT_BIT = 0;

    // Channel mode codes
    typedef enum logic [3:0] {
        CPW_MODE_OFF = 4'b0000,
        CPW_MODE_TOGGLE_CLR = 4'b0001,
        CPW_MODE_TOGGLE = 4'b0010,
        CPW_MODE_SET = 4'b1000,
        CPW_MODE_CLEAR = 4'b1001,
        CPW_MODE_SW_PULSE = 4'b1010,
        CPW_MODE_PULSE_CLR = 4'b1011
    } cpw_mode_type;
    localparam logic [1:0] CPW_PWM_MODE_TOP = 2'b11;

    // Period timer selection and prescale codes
    localparam int CPW_NUM_TIMERS = 3;
    localparam logic [1:0] CPW_TSEL_RESERVED = 2'b11;
    localparam logic [1:0] CPW_PRESCALE_1TO1 = 2'b00;

    // One period-timer step spans four system clocks at 1:1 prescale
    localparam int CPW_CLK_MHZ = 100;
    localparam int CPW_STEP_CLOCKS = 4;
    localparam logic [1:0] CPW_PHASE_ZERO = 2'h0;
    localparam logic [1:0] CPW_PHASE_ONE = 2'h1;
    localparam logic [9:0] CPW_DUTY_ZERO = 10'h000;
endpackage

// File: cpw_channel.sv
// What this block does
// - Mode 1010 never takes the pin; only internal compare output and flag react.
// - Compare runs on the system clock; a stopped clock detects no match.
// - Modes 1011 and 1010 drive compare output high while timer equals holding pair.
// - Modes 0001 and 0010 invert the output on each match.
// - Mode 1001 drives output low on match; mode 1000 drives it high.
// - Compare output feeds neighbour logic and the pin remap unit.
// - PWM mode makes a pulse of up to 10 bits on the pin.
// - Control register all zeros releases the pin.
// - The channel has its own selection of period timer.
// - PWM period is (limit+1) times four clocks times prescale.
// - On step after timer equals limit, set pin unless duty zero, latch duty.
// - The period timer postscaler has no effect on PWM.
// - Alignment 0: duty upper bits in high byte 1:0, lower eight in low byte.
// - Alignment 1: duty low bits in low byte 7:6, upper eight in high byte.
// - Duty writes take effect only after the current period ends.
// - Time base is timer plus two low bits from phase counter or prescaler.
// - When time base equals latched duty, pin goes low for the period rest.
// - Duty resolution reaches ten bits only when limit is 255.
// - A pulse width beyond the period leaves the pin level unchanged.
// - Mode 11xx selects PWM; mode 0000 turns off and resets internal state.
// - Modes 0001 and 1011 also clear the 16-bit timer on a match.
// - Timer select 00, 01, 10 pick timers one to three; 11 is reserved.
// - Enable bit turns the channel on; read-only bit shows output level.
`timescale 1ns/10ps
`default_nettype none
module cpw_channel #(
    parameter int TIMER_COUNT = cpw_pkg::CPW_NUM_TIMERS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [cpw_pkg::CPW_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cpw_pkg::CPW_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [cpw_pkg::CPW_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Sixteen-bit time base
    input wire logic [15:0] sixteen_bit_timebase,
    output logic timebase_clear,
    // Eight-bit period timers
    input wire logic [TIMER_COUNT-1:0][7:0] eight_bit_period_timer,
    input wire logic [TIMER_COUNT-1:0][7:0] period_limit_value,
    input wire logic [TIMER_COUNT-1:0][1:0] timer_prescale_field,
    input wire logic [TIMER_COUNT-1:0][1:0] prescaler_low_bits,
    input wire logic [TIMER_COUNT-1:0] period_timer_step,
    // Pin and internal outputs
    output logic cmp_pwm_channel_pin,
    output logic cmp_pwm_channel_pin_oe,
    output logic channel_signal,
    output logic compare_event
);
    import cpw_pkg::*;

    logic [7:0] channel_control_reg;
    logic [7:0] holding_low_byte_reg;
    logic [7:0] holding_high_byte_reg;
    logic [1:0] pwm_timer_select_reg;
    logic compare_event_flag_reg;
    logic ack_reg;
    logic out_reg;
    logic match_reg;
    logic [1:0] phase_reg;
    logic [9:0] duty_latch_reg;
    logic timebase_clear_reg;
    logic compare_event_reg;

    logic enable;
    logic [3:0] mode;
    logic fmt;
    logic pwm_mode;
    logic compare_mode;
    logic bus_req;
    logic bus_write;
    logic bus_read;
    logic status_clear;
    logic match_now;
    logic match_rise;
    logic [15:0] holding_pair;
    logic [9:0] pulse_width_value;
    logic [TIMER_COUNT-1:0] reload_hit;
    logic reload;
    logic [7:0] sel_count;
    logic [1:0] sel_prescale;
    logic [1:0] sel_low;
    logic sel_step;
    logic [1:0] tb_low;
    logic [9:0] tb_now;
    logic tb_carry;
    logic pulse_mode;

    assign enable = channel_control_reg[CPW_CTL_EN_BIT];
    assign mode = channel_control_reg[CPW_CTL_MODE_LSB +: CPW_MODE_W];
    assign fmt = channel_control_reg[CPW_CTL_FMT_BIT];
    assign pwm_mode = enable && (mode[3:2] == CPW_PWM_MODE_TOP);
    assign compare_mode = enable && (mode == CPW_MODE_TOGGLE_CLR || mode == CPW_MODE_TOGGLE
        || mode == CPW_MODE_SET || mode == CPW_MODE_CLEAR || mode == CPW_MODE_SW_PULSE
        || mode == CPW_MODE_PULSE_CLR);
    assign pulse_mode = (mode == CPW_MODE_SW_PULSE) || (mode == CPW_MODE_PULSE_CLR);

    // Bus: one wait cycle, then the access completes
    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !ack_reg;
    assign bus_write = avs_write && ack_reg && avs_byteenable[0];
    assign bus_read = avs_read && !ack_reg;
    assign status_clear = bus_write && (avs_address == CPW_ADDR_STATUS)
        && avs_writedata[CPW_STAT_EVENT_BIT];

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req && !ack_reg;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (bus_read) begin
            case (avs_address)
                CPW_ADDR_CONTROL: begin
                    avs_readdata <= {24'h000000, channel_control_reg[7:6], out_reg,
                        channel_control_reg[4:0]};
                end
                CPW_ADDR_HOLD_LOW: avs_readdata <= {24'h000000, holding_low_byte_reg};
                CPW_ADDR_HOLD_HIGH: avs_readdata <= {24'h000000, holding_high_byte_reg};
                CPW_ADDR_TIMER_SEL: avs_readdata <= {30'h00000000, pwm_timer_select_reg};
                CPW_ADDR_STATUS: avs_readdata <= {31'h00000000, compare_event_flag_reg};
                default: avs_readdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            channel_control_reg <= CPW_CTL_RESET;
            holding_low_byte_reg <= CPW_HOLD_RESET;
            holding_high_byte_reg <= CPW_HOLD_RESET;
            pwm_timer_select_reg <= CPW_TSEL_RESET;
        end else if (bus_write) begin
            case (avs_address)
                CPW_ADDR_CONTROL: channel_control_reg <= avs_writedata[7:0] & CPW_CTL_WRITE_MASK;
                // Duty may change at any time; the latch below shields the pin
                CPW_ADDR_HOLD_LOW: holding_low_byte_reg <= avs_writedata[7:0];
                CPW_ADDR_HOLD_HIGH: holding_high_byte_reg <= avs_writedata[7:0];
                CPW_ADDR_TIMER_SEL: pwm_timer_select_reg <= avs_writedata[1:0];
                default: ;
            endcase
        end
    end

    // Compare path; with the clock stopped nothing here advances
    assign holding_pair = {holding_high_byte_reg, holding_low_byte_reg};
    assign match_now = compare_mode && (sixteen_bit_timebase == holding_pair);
    assign match_rise = match_now && !match_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match_now;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            compare_event_flag_reg <= 1'b0;
            compare_event_reg <= 1'b0;
        end else begin
            compare_event_reg <= match_rise;
            // A new match wins over a clear in the same cycle
            if (match_rise) begin
                compare_event_flag_reg <= 1'b1;
            end else if (status_clear) begin
                compare_event_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            timebase_clear_reg <= 1'b0;
        end else begin
            timebase_clear_reg <= match_rise && ((mode == CPW_MODE_TOGGLE_CLR)
                || (mode == CPW_MODE_PULSE_CLR));
        end
    end

    // Period timer selection; postscaler is deliberately not an input
    generate
        for (genvar i = 0; i < TIMER_COUNT; i++) begin : g_reload
            assign reload_hit[i] = period_timer_step[i]
                && (eight_bit_period_timer[i] == period_limit_value[i]);
        end
    endgenerate

    always_comb begin
        sel_count = '0;
        sel_prescale = CPW_PRESCALE_1TO1;
        sel_low = '0;
        sel_step = 1'b0;
        reload = 1'b0;
        if (pwm_timer_select_reg != CPW_TSEL_RESERVED
            && int'(pwm_timer_select_reg) < TIMER_COUNT) begin
            sel_count = eight_bit_period_timer[pwm_timer_select_reg];
            sel_prescale = timer_prescale_field[pwm_timer_select_reg];
            sel_low = prescaler_low_bits[pwm_timer_select_reg];
            sel_step = period_timer_step[pwm_timer_select_reg];
            reload = reload_hit[pwm_timer_select_reg];
        end
    end

    // Duty value unpacked from the holding pair by alignment
    assign pulse_width_value = fmt ? {holding_high_byte_reg, holding_low_byte_reg[7:6]}
        : {holding_high_byte_reg[1:0], holding_low_byte_reg};

    // Phase counter restarts with each timer step so the low bits stay aligned
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg <= CPW_PHASE_ZERO;
        end else if (sel_step) begin
            phase_reg <= CPW_PHASE_ONE;
        end else begin
            phase_reg <= phase_reg + CPW_PHASE_ONE;
        end
    end

    assign tb_low = (sel_prescale == CPW_PRESCALE_1TO1) ? phase_reg : sel_low;
    // At 1:1 the low bits run one clock ahead, so their wrap to zero belongs to the next count
    assign tb_carry = (sel_prescale == CPW_PRESCALE_1TO1) && (phase_reg == CPW_PHASE_ZERO);
    assign tb_now = {sel_count + {7'h00, tb_carry}, tb_low};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            duty_latch_reg <= CPW_DUTY_ZERO;
        end else if (!pwm_mode) begin
            duty_latch_reg <= CPW_DUTY_ZERO;
        end else if (reload) begin
            duty_latch_reg <= pulse_width_value;
        end
    end

    // Output level for every mode
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_reg <= 1'b0;
        end else if (!enable || mode == CPW_MODE_OFF) begin
            out_reg <= 1'b0;
        end else if (pwm_mode) begin
            if (reload) begin
                out_reg <= (pulse_width_value != CPW_DUTY_ZERO);
            end else if (tb_now == duty_latch_reg) begin
                // Width beyond the period never matches, so the level holds
                out_reg <= 1'b0;
            end
        end else if (compare_mode) begin
            if (pulse_mode) begin
                out_reg <= match_now;
            end else if (match_rise) begin
                case (mode)
                    CPW_MODE_TOGGLE_CLR: out_reg <= !out_reg;
                    CPW_MODE_TOGGLE: out_reg <= !out_reg;
                    CPW_MODE_SET: out_reg <= 1'b1;
                    CPW_MODE_CLEAR: out_reg <= 1'b0;
                    default: out_reg <= out_reg;
                endcase
            end
        end
    end

    // Pin ownership: off, disabled and the software-event mode leave the pin alone
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cmp_pwm_channel_pin_oe <= 1'b0;
        end else begin
            cmp_pwm_channel_pin_oe <= (pwm_mode || compare_mode)
                && (mode != CPW_MODE_SW_PULSE);
        end
    end

    assign cmp_pwm_channel_pin = out_reg;
    assign channel_signal = out_reg;
    assign compare_event = compare_event_reg;
    assign timebase_clear = timebase_clear_reg;

    // Checks
    AST_SW_MODE_NO_PIN: assert property (@(posedge clock) disable iff (sys_rst)
        (enable && mode == CPW_MODE_SW_PULSE) |=> !cmp_pwm_channel_pin_oe)
        else $error("pin taken in software event mode");

    AST_PULSE_FOLLOWS_MATCH: assert property (@(posedge clock) disable iff (sys_rst)
        (compare_mode && pulse_mode && $stable(channel_control_reg))
        |=> (channel_signal == $past(match_now)))
        else $error("pulse output does not follow the match");

    AST_TOGGLE_ON_MATCH: assert property (@(posedge clock) disable iff (sys_rst)
        (match_rise && (mode == CPW_MODE_TOGGLE || mode == CPW_MODE_TOGGLE_CLR))
        |=> (channel_signal != $past(channel_signal)))
        else $error("toggle missed on match");

    AST_SET_CLEAR_ON_MATCH: assert property (@(posedge clock) disable iff (sys_rst)
        (match_rise && (mode == CPW_MODE_SET || mode == CPW_MODE_CLEAR))
        |=> (channel_signal == ($past(mode) == CPW_MODE_SET)))
        else $error("set or clear wrong on match");

    AST_ZERO_RELEASES_PIN: assert property (@(posedge clock) disable iff (sys_rst)
        (channel_control_reg == CPW_CTL_RESET) |=> !cmp_pwm_channel_pin_oe && !out_reg)
        else $error("pin held with control cleared");

    AST_RELOAD_SETS_PIN: assert property (@(posedge clock) disable iff (sys_rst)
        (pwm_mode && reload) |=> (cmp_pwm_channel_pin == (duty_latch_reg != CPW_DUTY_ZERO))
        && (duty_latch_reg == $past(pulse_width_value)))
        else $error("period start wrong");

    AST_DUTY_CLEARS_PIN: assert property (@(posedge clock) disable iff (sys_rst)
        (pwm_mode && !reload && tb_now == duty_latch_reg && $stable(channel_control_reg))
        |=> !cmp_pwm_channel_pin)
        else $error("pin not cleared at duty match");

    AST_TIMER_CLEAR_PULSE: assert property (@(posedge clock) disable iff (sys_rst)
        (match_rise && (mode == CPW_MODE_TOGGLE_CLR || mode == CPW_MODE_PULSE_CLR))
        |=> timebase_clear ##1 !timebase_clear)
        else $error("timer clear pulse missing");

    AST_EVENT_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
        match_rise |=> compare_event && compare_event_flag_reg)
        else $error("compare event not flagged");

    AST_DUTY_HELD: assert property (@(posedge clock) disable iff (sys_rst)
        (pwm_mode && $past(pwm_mode) && !$past(reload)) |-> $stable(duty_latch_reg))
        else $error("duty latch changed mid period");

    AST_PWM_TAKES_PIN: assert property (@(posedge clock) disable iff (sys_rst)
        pwm_mode |=> cmp_pwm_channel_pin_oe)
        else $error("pin not taken in pwm mode");

    AST_OFF_CLEARS_LATCH: assert property (@(posedge clock) disable iff (sys_rst)
        !pwm_mode |=> (duty_latch_reg == CPW_DUTY_ZERO))
        else $error("duty latch kept outside pwm mode");

    AST_ZERO_DUTY_LOW: assert property (@(posedge clock) disable iff (sys_rst)
        (pwm_mode && reload && pulse_width_value == CPW_DUTY_ZERO) |=> !cmp_pwm_channel_pin)
        else $error("pin set with zero duty");

    AST_CLEAR_ONLY_CLR_MODES: assert property (@(posedge clock) disable iff (sys_rst)
        (match_rise && mode != CPW_MODE_TOGGLE_CLR && mode != CPW_MODE_PULSE_CLR)
        |=> !timebase_clear)
        else $error("timer clear in a mode without clear");

    AST_EVENT_NEEDS_MATCH: assert property (@(posedge clock) disable iff (sys_rst)
        compare_event |-> $past(match_rise))
        else $error("compare event without match");

    AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (sys_rst)
        (compare_event_flag_reg && !status_clear) |=> compare_event_flag_reg)
        else $error("event flag lost without clear");

    AST_OUT_BIT_READ: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_read && avs_address == CPW_ADDR_CONTROL)
        |=> (avs_readdata[CPW_CTL_OUT_BIT] == $past(out_reg)))
        else $error("output bit read wrong");

    AST_RESERVED_NO_PERIOD: assert property (@(posedge clock) disable iff (sys_rst)
        (pwm_mode && pwm_timer_select_reg == CPW_TSEL_RESERVED) |=> $stable(duty_latch_reg))
        else $error("reserved timer select reloaded duty");

    AST_WAIT_ONE_CYCLE: assert property (@(posedge clock) disable iff (sys_rst)
        (bus_req && !ack_reg) |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule
`default_nettype wire

// File: cpw_timer_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpw_timer_model (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Bench control
    input wire logic restart_timebase,
    // Channel side
    input wire logic timebase_clear,
    output logic [15:0] sixteen_bit_timebase,
    output logic [2:0][7:0] eight_bit_period_timer,
    output logic [2:0][7:0] period_limit_value,
    output logic [2:0][1:0] timer_prescale_field,
    output logic [2:0][1:0] prescaler_low_bits,
    output logic [2:0] period_timer_step
);
    logic [1:0] div_reg;
    // Distinct limits so every timer selection gives its own period
    assign period_limit_value = {8'h01, 8'h07, 8'h03};
    assign timer_prescale_field = {3{2'h0}};
    assign prescaler_low_bits = {3{div_reg}};
    // Steps once per four system clocks; no postscaler exists here
    assign period_timer_step = {3{div_reg == 2'h3}};
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            eight_bit_period_timer <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (period_timer_step[i]) begin
                    if (eight_bit_period_timer[i] == period_limit_value[i]) begin
                        eight_bit_period_timer[i] <= 8'h00;
                    end else begin
                        eight_bit_period_timer[i] <= eight_bit_period_timer[i] + 8'h01;
                    end
                end
            end
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sixteen_bit_timebase <= 16'h0000;
        end else if (restart_timebase || timebase_clear) begin
            sixteen_bit_timebase <= 16'h0000;
        end else begin
            sixteen_bit_timebase <= sixteen_bit_timebase + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cpw_pkg::*;
    logic clock = 1'h0;
    logic sys_rst = 1'h1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] sixteen_bit_timebase;
    logic timebase_clear;
    logic [2:0][7:0] eight_bit_period_timer;
    logic [2:0][7:0] period_limit_value;
    logic [2:0][1:0] timer_prescale_field;
    logic [2:0][1:0] prescaler_low_bits;
    logic [2:0] period_timer_step;
    logic cmp_pwm_channel_pin;
    logic cmp_pwm_channel_pin_oe;
    logic channel_signal;
    logic compare_event;
    logic restart_timebase = 1'h0;
    logic clr_seen;
    logic [31:0] rd;
    int fails = 0;
    int checks_done = 0;
    int pin_hi;
    int sig_hi;
    int oe_hi;
    int tsel_exp[3] = '{12, 6, 24};

    always #5 clock = ~clock;

    cpw_channel #(.TIMER_COUNT(3)) DUT (.clock, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sixteen_bit_timebase,
        .timebase_clear, .eight_bit_period_timer, .period_limit_value, .timer_prescale_field,
        .prescaler_low_bits, .period_timer_step, .cmp_pwm_channel_pin, .cmp_pwm_channel_pin_oe,
        .channel_signal, .compare_event);
    cpw_timer_model timers (.clock, .sys_rst, .restart_timebase, .timebase_clear,
        .sixteen_bit_timebase, .eight_bit_period_timer, .period_limit_value,
        .timer_prescale_field, .prescaler_low_bits, .period_timer_step);

    task automatic give_verdict;
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= 4'hF;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        if (avs_waitrequest !== 1'h0) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic restart;
        @(posedge clock);
        restart_timebase <= 1'h1;
        @(posedge clock);
        restart_timebase <= 1'h0;
    endtask
    task automatic wait_event;
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (compare_event !== 1'h1 && n < 200);
        clr_seen = timebase_clear;
        if (compare_event !== 1'h1) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic measure(input int cyc);
        pin_hi = 0;
        sig_hi = 0;
        oe_hi = 0;
        repeat (cyc) begin
            @(posedge clock);
            pin_hi += (cmp_pwm_channel_pin === 1'h1);
            sig_hi += (channel_signal === 1'h1);
            oe_hi += (cmp_pwm_channel_pin_oe === 1'h1);
        end
    endtask
    // Settle two full periods so the new duty is latched before counting
    task automatic pwm(input logic [1:0] ts, input logic [7:0] hi, input logic [7:0] lo,
                       input logic [7:0] ctl, input int exp);
        bus(1'h1, CPW_ADDR_TIMER_SEL, {6'h00, ts});
        bus(1'h1, CPW_ADDR_HOLD_HIGH, hi);
        bus(1'h1, CPW_ADDR_HOLD_LOW, lo);
        bus(1'h1, CPW_ADDR_CONTROL, ctl);
        repeat (80) @(posedge clock);
        measure(64);
        check(pin_hi, exp);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            bus(1'h0, 5'(i * 4), 8'h00);
            check(rd, 32'h0);
        end
        $display("test reset_values done");
        bus(1'h1, CPW_ADDR_HOLD_LOW, 8'h10);
        bus(1'h1, CPW_ADDR_HOLD_HIGH, 8'h00);
        bus(1'h1, CPW_ADDR_CONTROL, 8'h88);
        restart();
        wait_event();
        check(cmp_pwm_channel_pin, 32'h1);
        check(channel_signal, 32'h1);
        bus(1'h0, CPW_ADDR_CONTROL, 8'h00);
        check(rd, 32'hA8);
        bus(1'h0, CPW_ADDR_STATUS, 8'h00);
        check(rd, 32'h1);
        bus(1'h1, CPW_ADDR_STATUS, 8'h01);
        bus(1'h0, CPW_ADDR_STATUS, 8'h00);
        check(rd, 32'h0);
        bus(1'h1, CPW_ADDR_CONTROL, 8'h89);
        restart();
        wait_event();
        check(cmp_pwm_channel_pin, 32'h0);
        bus(1'h1, CPW_ADDR_CONTROL, 8'h82);
        restart();
        wait_event();
        check(cmp_pwm_channel_pin, 32'h1);
        check(clr_seen, 32'h0);
        restart();
        wait_event();
        check(cmp_pwm_channel_pin, 32'h0);
        $display("test compare_levels done");
        bus(1'h1, CPW_ADDR_CONTROL, 8'h00);
        repeat (3) @(posedge clock);
        check(cmp_pwm_channel_pin_oe, 32'h0);
        check(channel_signal, 32'h0);
        bus(1'h1, CPW_ADDR_CONTROL, 8'h8A);
        restart();
        measure(40);
        check(sig_hi, 32'h1);
        check(oe_hi, 32'h0);
        for (int i = 0; i < 2; i++) begin
            bus(1'h1, CPW_ADDR_CONTROL, (i == 0) ? 8'h81 : 8'h8B);
            restart();
            wait_event();
            check(clr_seen, 32'h1);
        end
        bus(1'h1, CPW_ADDR_CONTROL, 8'h00);
        $display("test compare_pulse done");
        pwm(2'h0, 8'h00, 8'h06, 8'h8C, 24);
        check(cmp_pwm_channel_pin_oe, 32'h1);
        pwm(2'h0, 8'h02, 8'h40, 8'h9C, 36);
        pwm(2'h0, 8'h00, 8'h00, 8'h8C, 0);
        pwm(2'h0, 8'h00, 8'h04, 8'h8C, 16);
        pwm(2'h0, 8'h03, 8'hFF, 8'h8C, 64);
        for (int i = 0; i < 3; i++) begin
            pwm(2'(i), 8'h00, 8'h03, 8'h8C, tsel_exp[i]);
        end
        pwm(2'h3, 8'h00, 8'h03, 8'h8C, 0);
        $display("test pwm done");
        give_verdict();
    end
endmodule
`default_nettype wire
